// [verilog/bcri_regs.vh]
// register offsets, command codes and field values of the command interpreter
`ifndef BCRI_REGS_VH
`define BCRI_REGS_VH
`define BCRI_OFS_CODE      16'h1F3F
`define BCRI_OFS_PCOUNT    16'h1F40
`define BCRI_OFS_DEST      16'h1F41
`define BCRI_OFS_SECTYPE   16'h1F42
`define BCRI_OFS_PW_HI     16'h1F43
`define BCRI_OFS_PW_LO     16'h1F44
`define BCRI_OFS_PARAM1    16'h1F45
`define BCRI_OFS_PARAM2    16'h1F46
`define BCRI_OFS_LAST      16'h1F53
`define BCRI_OFS_STATUS    16'h1F54
`define BCRI_OFS_BYTES     16'h1F55
`define BCRI_OFS_DT0       16'h1F56
`define BCRI_OFS_DT1       16'h1F57
`define BCRI_OFS_DT2       16'h1F58
`define BCRI_OFS_DT3       16'h1F59
`define BCRI_CMD_OPEN      16'h0388
`define BCRI_CMD_CLOSE     16'h0389
`define BCRI_CMD_INHIBIT   16'h038E
`define BCRI_CMD_DATETIME  16'h0300
`define BCRI_CMD_EVRESET   16'hC388
`define BCRI_CMD_EVGET     16'hC580
`define BCRI_CMD_MODLIST   16'hC680
`define BCRI_CMD_MODINFO   16'hC681
`define BCRI_PCNT_STD      16'h000A
`define BCRI_PCNT_INHIBIT  16'h000D
`define BCRI_PCNT_EVGET    16'h001B
`define BCRI_DEST_BREAKER  16'h1501
`define BCRI_DEST_UNIT     16'h1500
`define BCRI_SEC_NONE      16'h0000
`define BCRI_SEC_USER      16'h0001
`define BCRI_ORIGIN_REMOTE 16'h0001
`define BCRI_DT_BYTES      16'h0008
`define BCRI_ST_OK         16'h0000
`define BCRI_ST_BADARG     16'h0001
`define BCRI_ST_DENIED     16'h0002
`define BCRI_ST_UNKNOWN    16'h0003
`define BCRI_ST_INHIBITED  16'h0004
`endif

// [verilog/bcri_interp.v]
// command register block and interpreter of the breaker trip unit
// Functional notes
// [R1] code, count, destination, security and password form one request.
// [R2] code 904 with count 10 opens the breaker.
// [R3] code 905 with count 10 closes the breaker.
// [R4] code 910 with count 13 sets whether link close orders are allowed.
// [R5] for code 910 the first parameter 0 permits, 1 blocks link closes.
// [R6] for code 910 the master sets the origin parameter to 1 (remote).
// [R7] operations use dest 0x1501, security 1, admin or operator password.
// [R8] read time: code 768, count 10, dest 0x1500, security 0, password 0.
// [R9] each command leaves its code and a status, 0 meaning success.
// [R10] a date-time read reports 8 bytes and four date-time words.
// [R11] code 50056 with count 10 clears the recorded events.
// [R12] event retrieval, module listing and module detail need no password.
// [R13] the master confirms the breaker position in its status register; the interpreter has no breaker position input or result word.
// [R14] a mismatched request gets a nonzero status and causes no action.
`timescale 1ns/10ps
`include "bcri_regs.vh"
module bcri_interp (
	CLK,
	SRST,
	REG_ADDR,
	REG_WDATA,
	REG_WE,
	REG_RE,
	REG_RDATA,
	REG_ERR,
	ADMIN_PASSWORD,
	OPER_PASSWORD,
	CALENDAR_TIME,
	BREAKER_OPEN,
	BREAKER_CLOSE,
	EVENTS_CLEAR,
	CLOSE_INHIBIT,
	CMD_BUSY
);
	input  wire        CLK;
	input  wire        SRST;
	input  wire [15:0] REG_ADDR;
	input  wire [15:0] REG_WDATA;
	input  wire        REG_WE;
	input  wire        REG_RE;
	output reg  [15:0] REG_RDATA;
	output reg         REG_ERR;
	input  wire [31:0] ADMIN_PASSWORD;
	input  wire [31:0] OPER_PASSWORD;
	input  wire [63:0] CALENDAR_TIME;
	output reg         BREAKER_OPEN;
	output reg         BREAKER_CLOSE;
	output reg         EVENTS_CLEAR;
	output reg         CLOSE_INHIBIT;
	output wire        CMD_BUSY;

	// one execute cycle per request, so no long counts are needed
	localparam ST_IDLE = 1'b0;
	localparam ST_EXEC = 1'b1;

	reg  [15:0] code_q;
	reg  [15:0] pcount_q;
	reg  [15:0] dest_q;
	reg  [15:0] sectype_q;
	reg  [31:0] password_q;
	reg  [15:0] param1_q;
	reg  [15:0] param2_q;
	reg  [15:0] last_q;
	reg  [15:0] status_q;
	reg  [15:0] bytes_q;
	reg  [63:0] datetime_q;

	reg         state_q;
	reg         state_d;
	reg  [15:0] status_d;
	reg         do_open;
	reg         do_close;
	reg         do_clear;
	reg         do_inhibit;
	reg         do_time;
	wire        user_ok;
	wire        free_ok;
	wire        code_take;
	wire        access;

	// a profile password of zero is treated as unassigned and never matches
	function pw_match;
		input [31:0] given;
		input [31:0] stored;
		begin
			pw_match = (stored != 32'h0000_0000) && (given == stored);
		end
	endfunction

	function in_range;
		input [15:0] a;
		input [15:0] lo;
		input [15:0] hi;
		begin
			in_range = (a >= lo) && (a <= hi);
		end
	endfunction

	// a fixed-count request from an administrator or operator profile
	function user_req;
		input [15:0] count;
		input [15:0] need;
		input        auth;
		begin
			user_req = (count == need) && auth;
		end
	endfunction

	// operations need the breaker destination and a live profile password
	assign user_ok = (dest_q == `BCRI_DEST_BREAKER) &&
		(sectype_q == `BCRI_SEC_USER) &&
		(pw_match(password_q, ADMIN_PASSWORD) ||
		pw_match(password_q, OPER_PASSWORD)); // R7
	// password-free requests carry security 0 and an all-zero password
	assign free_ok = (sectype_q == `BCRI_SEC_NONE) &&
		(password_q == 32'h0000_0000); // R12
	// the master must not rewrite the block while a request is in flight
	assign CMD_BUSY = (state_q == ST_EXEC);
	// a code write during the execute cycle is dropped like any other write
	assign code_take = REG_WE && !CMD_BUSY &&
		(REG_ADDR == `BCRI_OFS_CODE); // R1
	assign access = REG_WE || REG_RE;

	// command block writes; a code write launches the request
	always @(posedge CLK)
	begin
		if (SRST)
		begin
			code_q     <= 16'h0000;
			pcount_q   <= 16'h0000;
			dest_q     <= 16'h0000;
			sectype_q  <= 16'h0000;
			password_q <= 32'h0000_0000;
			param1_q   <= 16'h0000;
			param2_q   <= 16'h0000;
		end
		else if (REG_WE && !CMD_BUSY)
		begin
			case (REG_ADDR)
				`BCRI_OFS_CODE:    code_q <= REG_WDATA; // R1
				`BCRI_OFS_PCOUNT:  pcount_q <= REG_WDATA;
				`BCRI_OFS_DEST:    dest_q <= REG_WDATA;
				`BCRI_OFS_SECTYPE: sectype_q <= REG_WDATA;
				// the two password halves may arrive in either order
				`BCRI_OFS_PW_HI:   password_q[31:16] <= REG_WDATA;
				`BCRI_OFS_PW_LO:   password_q[15:0] <= REG_WDATA;
				`BCRI_OFS_PARAM1:  param1_q <= REG_WDATA;
				`BCRI_OFS_PARAM2:  param2_q <= REG_WDATA;
				default:           code_q <= code_q;
			endcase
		end
	end

	// decode one launched request into a status and at most one action
	always @*
	begin
		state_d    = ST_IDLE;
		status_d   = `BCRI_ST_UNKNOWN;
		do_open    = 1'b0;
		do_close   = 1'b0;
		do_clear   = 1'b0;
		do_inhibit = 1'b0;
		do_time    = 1'b0;
		case (state_q)
			ST_IDLE:
				state_d = code_take ? ST_EXEC : ST_IDLE; // R1
			ST_EXEC:
				state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
		case (code_q)
			`BCRI_CMD_OPEN:
			begin
				status_d = user_req(pcount_q, `BCRI_PCNT_STD, user_ok) ?
					`BCRI_ST_OK : `BCRI_ST_DENIED; // R14
				do_open = (status_d == `BCRI_ST_OK); // R2
			end
			`BCRI_CMD_CLOSE:
			begin
				status_d = user_req(pcount_q, `BCRI_PCNT_STD, user_ok) ?
					`BCRI_ST_OK : `BCRI_ST_DENIED; // R14
				if (status_d == `BCRI_ST_OK && CLOSE_INHIBIT)
					status_d = `BCRI_ST_INHIBITED; // R4
				do_close = (status_d == `BCRI_ST_OK); // R3
			end
			`BCRI_CMD_INHIBIT:
			begin
				if (!user_req(pcount_q, `BCRI_PCNT_INHIBIT, user_ok))
					status_d = `BCRI_ST_DENIED; // R14
				else if (param1_q > 16'h0001 ||
					param2_q != `BCRI_ORIGIN_REMOTE)
					status_d = `BCRI_ST_BADARG; // R6
				else
					status_d = `BCRI_ST_OK;
				do_inhibit = (status_d == `BCRI_ST_OK); // R5
			end
			`BCRI_CMD_DATETIME:
			begin
				status_d = (pcount_q == `BCRI_PCNT_STD && free_ok &&
					dest_q == `BCRI_DEST_UNIT) ?
					`BCRI_ST_OK : `BCRI_ST_DENIED; // R8
				do_time = (status_d == `BCRI_ST_OK); // R10
			end
			`BCRI_CMD_EVRESET:
			begin
				status_d = user_req(pcount_q, `BCRI_PCNT_STD, user_ok) ?
					`BCRI_ST_OK : `BCRI_ST_DENIED; // R14
				do_clear = (status_d == `BCRI_ST_OK); // R11
			end
			`BCRI_CMD_EVGET:
				status_d = (pcount_q == `BCRI_PCNT_EVGET && free_ok &&
					dest_q == `BCRI_DEST_BREAKER) ?
					`BCRI_ST_OK : `BCRI_ST_DENIED; // R12
			default:
				// module listing and detail share one contiguous code range
				if (in_range(code_q, `BCRI_CMD_MODLIST, `BCRI_CMD_MODINFO))
					status_d = free_ok ? `BCRI_ST_OK :
						`BCRI_ST_DENIED; // R12
		endcase
	end

	// execution cycle: result area and one-cycle action pulses
	always @(posedge CLK)
	begin
		if (SRST)
		begin
			state_q       <= ST_IDLE;
			last_q        <= 16'h0000;
			// status resets to success so an idle unit reads clean
			status_q      <= `BCRI_ST_OK;
			bytes_q       <= 16'h0000;
			datetime_q    <= 64'h0000_0000_0000_0000;
			BREAKER_OPEN  <= 1'b0;
			BREAKER_CLOSE <= 1'b0;
			EVENTS_CLEAR  <= 1'b0;
			CLOSE_INHIBIT <= 1'b0;
		end
		else
		begin
			state_q       <= state_d;
			BREAKER_OPEN  <= 1'b0;
			BREAKER_CLOSE <= 1'b0;
			EVENTS_CLEAR  <= 1'b0;
			if (state_q == ST_EXEC)
			begin
				last_q        <= code_q; // R9
				status_q      <= status_d; // R9
				bytes_q       <= do_time ? `BCRI_DT_BYTES : 16'h0000; // R10
				// one capture keeps the four time words of an answer coherent
				datetime_q    <= do_time ? CALENDAR_TIME : 64'h0; // R10
				BREAKER_OPEN  <= do_open; // R2
				BREAKER_CLOSE <= do_close; // R3
				EVENTS_CLEAR  <= do_clear; // R11
				// the level persists until the next granted inhibition request or a reset
				if (do_inhibit)
					CLOSE_INHIBIT <= param1_q[0]; // R5
			end
		end
	end

	// register reads, one cycle after the strobe
	always @(posedge CLK)
	begin
		if (SRST)
		begin
			REG_RDATA <= 16'h0000;
			REG_ERR   <= 1'b0;
		end
		else
		begin
			// result words are read-only, so writing one flags an error
			REG_ERR <= access &&
				!in_range(REG_ADDR, `BCRI_OFS_CODE, `BCRI_OFS_PARAM2) &&
				!(REG_RE && in_range(REG_ADDR, `BCRI_OFS_LAST,
				`BCRI_OFS_DT3));
			// read data stands until the next access
			if (access)
			begin
				case (REG_ADDR)
					`BCRI_OFS_CODE:    REG_RDATA <= code_q;
					`BCRI_OFS_PCOUNT:  REG_RDATA <= pcount_q;
					`BCRI_OFS_DEST:    REG_RDATA <= dest_q;
					`BCRI_OFS_SECTYPE: REG_RDATA <= sectype_q;
					`BCRI_OFS_PW_HI:   REG_RDATA <= password_q[31:16];
					`BCRI_OFS_PW_LO:   REG_RDATA <= password_q[15:0];
					`BCRI_OFS_PARAM1:  REG_RDATA <= param1_q;
					`BCRI_OFS_PARAM2:  REG_RDATA <= param2_q;
					`BCRI_OFS_LAST:    REG_RDATA <= last_q; // R9
					`BCRI_OFS_STATUS:  REG_RDATA <= status_q; // R9
					`BCRI_OFS_BYTES:   REG_RDATA <= bytes_q; // R10
					`BCRI_OFS_DT0:     REG_RDATA <= datetime_q[63:48];
					`BCRI_OFS_DT1:     REG_RDATA <= datetime_q[47:32];
					`BCRI_OFS_DT2:     REG_RDATA <= datetime_q[31:16];
					`BCRI_OFS_DT3:     REG_RDATA <= datetime_q[15:0];
					default:           REG_RDATA <= 16'h0000;
				endcase
			end
		end
	end
endmodule // bcri_interp

// [test/bcri_asserts.sv]
// concurrent checks on the command interpreter ports
`timescale 1ns/10ps
module bcri_asserts (
	input logic        CLK,
	input logic        SRST,
	input logic [15:0] REG_ADDR,
	input logic [15:0] REG_WDATA,
	input logic        REG_WE,
	input logic        REG_RE,
	input logic [15:0] REG_RDATA,
	input logic        REG_ERR,
	input logic [31:0] ADMIN_PASSWORD,
	input logic [31:0] OPER_PASSWORD,
	input logic [63:0] CALENDAR_TIME,
	input logic        BREAKER_OPEN,
	input logic        BREAKER_CLOSE,
	input logic        EVENTS_CLEAR,
	input logic        CLOSE_INHIBIT,
	input logic        CMD_BUSY
);
	wire       wr_ok = REG_WE && !CMD_BUSY;
	wire [2:0] act   = {BREAKER_OPEN, BREAKER_CLOSE, EVENTS_CLEAR};
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	property p_go; wr_ok && REG_ADDR == 16'h1F3F |=> CMD_BUSY; endproperty
	a_go: assert property (p_go) else $error("code write not run");
	property p_one; CMD_BUSY |=> !CMD_BUSY; endproperty
	a_one: assert property (p_one) else $error("busy too long");
	property p_act; |act |-> $past(CMD_BUSY); endproperty
	a_act: assert property (p_act) else $error("action without command");
	property p_excl; $onehot0(act); endproperty
	a_excl: assert property (p_excl) else $error("two actions at once");
	property p_pulse; |act |=> act == 3'h0; endproperty
	a_pulse: assert property (p_pulse) else $error("action too long");
	property p_close; BREAKER_CLOSE |-> !CLOSE_INHIBIT; endproperty
	a_close: assert property (p_close) else $error("close while blocked");
	// a reset clears the level without any command behind it
	property p_inh;
		$changed(CLOSE_INHIBIT) && !$past(SRST) |-> $past(CMD_BUSY);
	endproperty
	a_inh: assert property (p_inh) else $error("inhibit changed alone");
	property p_ro; wr_ok && REG_ADDR == 16'h1F54 |=> REG_ERR; endproperty
	a_ro: assert property (p_ro) else $error("status write accepted");
	property p_unm;
		REG_RE && REG_ADDR == 16'h0000 |=> REG_ERR && REG_RDATA == 16'h0000;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped read passed");
	c_open: cover property (BREAKER_OPEN);
	c_close: cover property (BREAKER_CLOSE);
	c_clr: cover property (EVENTS_CLEAR);
	c_inh: cover property ($rose(CLOSE_INHIBIT));
endmodule // bcri_asserts
bind bcri_interp bcri_asserts u_asserts (.*);

// [test/bcri_master.sv]
// register master model issuing command blocks
`timescale 1ns/10ps
module bcri_master (
	input  logic        CLK,
	input  logic [15:0] REG_RDATA,
	input  logic        REG_ERR,
	output logic [15:0] REG_ADDR,
	output logic [15:0] REG_WDATA,
	output logic        REG_WE,
	output logic        REG_RE
);
	initial {REG_ADDR, REG_WDATA, REG_WE, REG_RE} = 34'h0;
	// one access per two edges keeps clear of the execute cycle
	task acc(input logic w, input logic [15:0] a, d,
		output logic [15:0] q, output logic e);
		@(posedge CLK) #1;
		{REG_ADDR, REG_WDATA, REG_WE, REG_RE} = {a, d, w, !w};
		@(posedge CLK) #1;
		{q, e} = {REG_RDATA, REG_ERR};
		{REG_ADDR, REG_WDATA, REG_WE, REG_RE} = {~a, ~d, 2'h0};
	endtask
	task cmd(input logic [15:0] c, n, t, s, input logic [31:0] p,
		input logic [15:0] p1, p2);
		logic [111:0] v;
		logic [15:0]  q;
		logic         e;
		v = {n, t, s, p, p1, p2};
		for (int i = 0; i < 7; i++)
			acc(1'h1, 16'h1F40 + 16'(i), v[16 * (6 - i) +: 16], q, e);
		acc(1'h1, 16'h1F3F, c, q, e);
	endtask
endmodule // bcri_master

// [test/tb_bcri_interp.sv]
// self-checking bench of the command interpreter
`timescale 1ns/10ps
module tb_bcri_interp;
	logic        CLK = 1'h0;
	logic        SRST = 1'h1;
	// profile passwords and clock value are arbitrary
	logic [31:0] ADMIN_PASSWORD = 32'h1357_2468;
	logic [31:0] OPER_PASSWORD = 32'h0A0B_0C0D;
	logic [63:0] CALENDAR_TIME = 64'h1122_3344_5566_7788;
	logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA, q;
	logic        REG_WE, REG_RE, REG_ERR, CMD_BUSY, CLOSE_INHIBIT, e;
	logic        BREAKER_OPEN, BREAKER_CLOSE, EVENTS_CLEAR;
	int          bad_count = 0;
	int          total_checks = 0;
	bcri_master mst (.*);
	bcri_interp dut (.*);
	initial forever #12.5 CLK = ~CLK;
	task chk(input logic [15:0] got, exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task final_report;
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task run(input logic [15:0] c, n, t, s, input logic [31:0] p,
		input logic [15:0] p1, p2, input logic [2:0] a, input logic [15:0] st);
		mst.cmd(c, n, t, s, p, p1, p2);
		chk({15'h0, CMD_BUSY}, 16'h0001);
		@(posedge CLK) #1;
		chk({15'h0, CMD_BUSY}, 16'h0000);
		chk({13'h0, BREAKER_OPEN, BREAKER_CLOSE, EVENTS_CLEAR}, {13'h0, a});
		mst.acc(1'h0, 16'h1F53, 16'h0000, q, e);
		chk(q, c);
		mst.acc(1'h0, 16'h1F54, 16'h0000, q, e);
		chk(q, st);
	endtask
	// origin word always 1, as a remote master must send it
	task ub(input logic [15:0] c, n, input logic [31:0] p,
		input logic [15:0] p1, input logic [2:0] a, input logic [15:0] st);
		run(c, n, 16'h1501, 16'h0001, p, p1, 16'h0001, a, st);
	endtask
	task np(input logic [15:0] c, n, t, st);
		run(c, n, t, 16'h0000, 32'h0, 16'h0000, 16'h0000, 3'h0, st);
	endtask
	task t_open;
		ub(16'h0388, 16'h000A, OPER_PASSWORD, 16'h0000, 3'h4, 16'h0000);
		ub(16'h0388, 16'h000A, 32'h0, 16'h0000, 3'h0, 16'h0002);
		ub(16'h0388, 16'h000B, OPER_PASSWORD, 16'h0000, 3'h0, 16'h0002);
		np(16'h0388, 16'h000A, 16'h1501, 16'h0002);
	endtask
	task t_close;
		ub(16'h038E, 16'h000D, ADMIN_PASSWORD, 16'h0001, 3'h0, 16'h0000);
		chk({15'h0, CLOSE_INHIBIT}, 16'h0001);
		ub(16'h0389, 16'h000A, OPER_PASSWORD, 16'h0000, 3'h0, 16'h0004);
		ub(16'h038E, 16'h000D, ADMIN_PASSWORD, 16'h0002, 3'h0, 16'h0001);
		run(16'h038E, 16'h000D, 16'h1501, 16'h0001, ADMIN_PASSWORD,
			16'h0001, 16'h0000, 3'h0, 16'h0001);
		chk({15'h0, CLOSE_INHIBIT}, 16'h0001);
		ub(16'h038E, 16'h000D, ADMIN_PASSWORD, 16'h0000, 3'h0, 16'h0000);
		chk({15'h0, CLOSE_INHIBIT}, 16'h0000);
		ub(16'h0389, 16'h000A, ADMIN_PASSWORD, 16'h0000, 3'h2, 16'h0000);
	endtask
	task t_date;
		np(16'h0300, 16'h000A, 16'h1500, 16'h0000);
		mst.acc(1'h0, 16'h1F55, 16'h0000, q, e);
		chk(q, 16'h0008);
		for (int i = 0; i < 4; i++)
		begin
			mst.acc(1'h0, 16'h1F56 + 16'(i), 16'h0000, q, e);
			chk(q, CALENDAR_TIME[63 - 16 * i -: 16]);
		end
		np(16'h0300, 16'h000A, 16'h1501, 16'h0002);
	endtask
	task t_events;
		ub(16'hC388, 16'h000A, OPER_PASSWORD, 16'h0000, 3'h1, 16'h0000);
		np(16'hC580, 16'h001B, 16'h1501, 16'h0000);
		np(16'hC680, 16'h000A, 16'h1500, 16'h0000);
		np(16'hC681, 16'h000A, 16'h1500, 16'h0000);
		np(16'h1234, 16'h000A, 16'h1500, 16'h0003);
	endtask
	task t_regs;
		mst.acc(1'h1, 16'h1F54, 16'hFFFF, q, e);
		chk({15'h0, e}, 16'h0001);
		mst.acc(1'h0, 16'h1F54, 16'h0000, q, e);
		chk(q, 16'h0003);
		mst.acc(1'h0, 16'h0000, 16'h0000, q, e);
		chk({15'h0, e}, 16'h0001);
		mst.acc(1'h0, 16'h1F41, 16'h0000, q, e);
		chk(q, 16'h1500);
	endtask
	task t_reset;
		ub(16'h038E, 16'h000D, ADMIN_PASSWORD, 16'h0001, 3'h0, 16'h0000);
		np(16'h1234, 16'h000A, 16'h1500, 16'h0003);
		SRST = 1'h1;
		repeat (8) @(posedge CLK);
		#1 SRST = 1'h0;
		chk({15'h0, CLOSE_INHIBIT}, 16'h0000);
		mst.acc(1'h0, 16'h1F53, 16'h0000, q, e);
		chk(q, 16'h0000);
		mst.acc(1'h0, 16'h1F54, 16'h0000, q, e);
		chk(q, 16'h0000);
	endtask
	initial
	begin
		repeat (8) @(posedge CLK);
		#1 SRST = 1'h0;
		t_open;
		t_close;
		t_date;
		t_events;
		t_regs;
		t_reset;
		final_report;
	end
	initial
	begin
		repeat (20000) @(posedge CLK);
		bad_count++;
		final_report;
	end
endmodule // tb_bcri_interp
